// file: dv/ledp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// twisted-pair side: line energy level and event pulses
// ----------------------------------------
module ledp_line_model (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           energy_on,
  input  wire logic           data_req,
  input  wire logic           err_req,
  output var  ledp_pkg::ledp_line_t line
);
  // events follow the requests one cycle late, so a held request gives a held event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line <= '0;
    end else begin
      line.line_energy <= energy_on;
      line.data_event  <= data_req;
      line.error_event <= err_req;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int QUIET = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        energy_on, data_req, err_req, drv_on, pulse_out, irq;
  logic [3:0]  dt;
  logic [15:0] w;
  int          failures, n_checks, cyc, pulses, base;
  ledp_pkg::ledp_line_t line_in;

  ledp_energy_detect #(.QUIET_CYCLES(QUIET)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_in(line_in), .driver_power_on(drv_on),
    .pulse_out(pulse_out), .irq(irq));
  ledp_line_model line_u (.pclk(pclk), .presetn(presetn), .energy_on(energy_on),
    .data_req(data_req), .err_req(err_req), .line(line_in));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pulse_out === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected control word: manual reads back 0 once taken
  function automatic logic [31:0] edc(input logic [15:0] c, input logic pw, eh, dh);
    return {16'h0, c[15:13], 1'b0, c[11], pw, eh, dh, c[7:0]};
  endfunction
  // setup then access, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no local limit: only the global cycle ceiling ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    check(rd, exp);
  endtask
  task automatic send(input int n, input logic is_err);
    repeat (n) begin
      @(posedge pclk);
      data_req <= !is_err;
      err_req <= is_err;
      @(posedge pclk);
      data_req <= 0;
      err_req <= 0;
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, data_req, err_req} = '0;
    {failures, n_checks} = '0;
    energy_on = 1;
    seed = 32'd47750;
    pause(16);
    presetn <= 1;
    rdchk(ledp_pkg::ADDR_EDC, edc(16'h6011, 0, 0, 0));
    check(drv_on, 0);
    apb(0, 12'h0f0, 0);
    check({rd[30:0], err}, 32'h1);
    apb(1, ledp_pkg::ADDR_IRQ_ENABLE, 32'h5);
    dt = 4'(xs() % 3 + 2);
    w = 16'he0f0 | dt;
    apb(1, ledp_pkg::ADDR_EDC, w); // crossover lives outside, kept off
    send(dt - 1, 0);
    pause(4);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 0, 0));
    check({drv_on, irq}, 0);
    base = pulses;
    send(1, 0);
    pause(12);
    check(drv_on, 1);
    check(pulses - base, 4);
    check(irq, 1);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 1, 0, 1));
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 1, 0, 0));
    rdchk(ledp_pkg::ADDR_IRQ_STATUS, 32'h5);
    apb(1, ledp_pkg::ADDR_IRQ_CLEAR, 32'h5);
    pause(2);
    check(irq, 0);
    energy_on <= 0;
    pause(6);
    check({drv_on, irq}, 0);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 0, 0));
    rdchk(ledp_pkg::ADDR_IRQ_STATUS, 32'h8);
    apb(1, ledp_pkg::ADDR_IRQ_CLEAR, 32'hf);
    energy_on <= 1;
    w = 16'h8821;
    base = pulses;
    apb(1, ledp_pkg::ADDR_EDC, w | 16'h1000);
    pause(12);
    check(drv_on, 1);
    check(pulses - base, 1);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 1, 0, 0));
    apb(1, ledp_pkg::ADDR_EDC, w);
    pause(6);
    check(drv_on, 1);
    apb(1, ledp_pkg::ADDR_EDC, w | 16'h1000);
    pause(6);
    check(drv_on, 0);
    send(2, 0);
    pause(4);
    check(drv_on, 0);
    pause(QUIET + 10);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 0, 1));
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 0, 0));
    send(1, 1);
    pause(4);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 0, 0));
    send(1, 1);
    pause(4);
    rdchk(ledp_pkg::ADDR_EDC, edc(w, 0, 1, 0));
    w = 16'he0f3;
    apb(1, ledp_pkg::ADDR_EDC, w);
    send(2, 0);
    pause(QUIET + 20);
    send(1, 0);
    pause(6);
    check(drv_on, 0);
    send(2, 0);
    pause(8);
    check(drv_on, 1);
    apb(1, ledp_pkg::ADDR_EDC, 16'h6011);
    pause(4);
    check(drv_on, 0);
    summarize();
  end
endmodule
`default_nettype wire

// file: logic/ledp_energy_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ledp_energy_detect #(
  parameter longint QUIET_CYCLES = ledp_pkg::QUIET_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire ledp_pkg::ledp_line_t line_in,
  output var  logic              driver_power_on,
  output var  logic              pulse_out,
  output var  logic              irq
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  ledp_pkg::ledp_ctrl_t            ctrl;
  ledp_pkg::ledp_state_t           state;
  logic                            manual_req;
  logic                            error_threshold_hit;
  logic                            data_threshold_hit;
  logic [3:0]                      data_cnt;
  logic [3:0]                      err_cnt;
  logic [31:0]                     quiet_cnt;
  logic [2:0]                      pulses_left;
  logic [ledp_pkg::IRQ_W-1:0]      irq_status;
  logic [ledp_pkg::IRQ_W-1:0]      irq_enable;
  logic                            wr_acc;
  logic                            rd_acc;
  logic                            rd_edc;
  logic                            data_met;
  logic                            err_met;
  logic                            go_up;
  logic                            go_down;
  logic [15:0]                     edc_word;
  logic [ledp_pkg::IRQ_W-1:0]      irq_ev;

  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign rd_edc = rd_acc && paddr == ledp_pkg::ADDR_EDC;
  assign data_met = data_cnt >= ctrl.data_event_threshold;
  assign err_met  = err_cnt >= ctrl.error_event_threshold;
  assign go_up   = state == ledp_pkg::LEDP_DOWN &&
                   (manual_req || (ctrl.auto_wake_enable && data_met));
  assign go_down = state == ledp_pkg::LEDP_UP &&
                   (manual_req || (ctrl.auto_sleep_enable && !line_in.line_energy));
  assign edc_word = {ctrl.energy_watch_enable, ctrl.auto_wake_enable, ctrl.auto_sleep_enable,
                     manual_req, ctrl.pulse_burst_disable, state == ledp_pkg::LEDP_UP,
                     error_threshold_hit, data_threshold_hit,
                     ctrl.error_event_threshold, ctrl.data_event_threshold};
  assign irq_ev = {go_down, go_up, err_met, data_met};

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        ledp_pkg::ADDR_EDC:        prdata <= {16'h0, edc_word};
        ledp_pkg::ADDR_IRQ_STATUS: prdata <= {28'h0, irq_status};
        ledp_pkg::ADDR_IRQ_ENABLE: prdata <= {28'h0, irq_enable};
        ledp_pkg::ADDR_IRQ_CLEAR:  prdata <= 32'h0;
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{1'b0, 1'b1, 1'b1, 1'b0, ledp_pkg::THR_RESET, ledp_pkg::THR_RESET};
    end else if (wr_acc && paddr == ledp_pkg::ADDR_EDC) begin
      ctrl.energy_watch_enable   <= pwdata[ledp_pkg::BIT_ENABLE];
      ctrl.auto_wake_enable      <= pwdata[ledp_pkg::BIT_AUTO_WAKE];
      ctrl.auto_sleep_enable     <= pwdata[ledp_pkg::BIT_AUTO_SLEEP];
      ctrl.pulse_burst_disable   <= pwdata[ledp_pkg::BIT_BURST_DIS];
      ctrl.error_event_threshold <= pwdata[ledp_pkg::ERR_THR_LSB +: 4];
      ctrl.data_event_threshold  <= pwdata[ledp_pkg::DATA_THR_LSB +: 4];
    end
  end

  // ----------------------------------------
  // manual toggle, self clearing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_req <= 1'b0;
    end else if (wr_acc && paddr == ledp_pkg::ADDR_EDC && pwdata[ledp_pkg::BIT_MANUAL]) begin
      manual_req <= 1'b1;
    end else if (go_up || go_down || state == ledp_pkg::LEDP_OFF) begin
      manual_req <= 1'b0;
    end
  end

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ledp_pkg::LEDP_OFF;
    end else if (!ctrl.energy_watch_enable) begin
      state <= ledp_pkg::LEDP_OFF;
    end else begin
      case (state)
        ledp_pkg::LEDP_OFF:  state <= ledp_pkg::LEDP_DOWN;
        ledp_pkg::LEDP_DOWN: if (go_up) begin
          state <= ledp_pkg::LEDP_UP;
        end
        ledp_pkg::LEDP_UP:   if (go_down) begin
          state <= ledp_pkg::LEDP_DOWN;
        end
        default: state <= ledp_pkg::LEDP_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // event counters and quiet timer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_cnt  <= 4'h0;
      err_cnt   <= 4'h0;
      quiet_cnt <= 32'h0;
    end else if (!ctrl.energy_watch_enable || go_up || go_down) begin
      data_cnt  <= 4'h0;
      err_cnt   <= 4'h0;
      quiet_cnt <= 32'h0;
    end else if (line_in.data_event) begin
      quiet_cnt <= 32'h0;
      if (data_cnt != 4'hf) begin
        data_cnt <= data_cnt + 4'h1;
      end
      if (line_in.error_event && err_cnt != 4'hf) begin
        err_cnt <= err_cnt + 4'h1;
      end
    end else if (quiet_cnt >= 32'(QUIET_CYCLES - 1)) begin
      data_cnt  <= 4'h0;
      err_cnt   <= 4'h0;
      quiet_cnt <= 32'h0;
    end else begin
      quiet_cnt <= quiet_cnt + 32'h1;
      if (line_in.error_event && err_cnt != 4'hf) begin
        err_cnt <= err_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // sticky clear on read flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_threshold_hit <= 1'b0;
      data_threshold_hit  <= 1'b0;
    end else begin
      // set beats the read clear; only a flag the read returned is cleared,
      // so one raised between setup and access is not lost unseen
      error_threshold_hit <= (ctrl.energy_watch_enable && err_met) ||
                             (error_threshold_hit &&
                              !(rd_edc && prdata[ledp_pkg::BIT_ERR_HIT]));
      data_threshold_hit  <= (ctrl.energy_watch_enable && data_met) ||
                             (data_threshold_hit &&
                              !(rd_edc && prdata[ledp_pkg::BIT_DATA_HIT]));
    end
  end

  // ----------------------------------------
  // line driver and pulse burst
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_power_on <= 1'b0;
      pulses_left     <= 3'h0;
      pulse_out       <= 1'b0;
    end else begin
      driver_power_on <= state == ledp_pkg::LEDP_UP;
      if (go_up) begin
        pulses_left <= ctrl.pulse_burst_disable ? ledp_pkg::SINGLE_PULSE
                                                : ledp_pkg::BURST_PULSES;
        pulse_out   <= 1'b0;
      end else if (pulses_left != 3'h0 && !pulse_out) begin
        pulse_out   <= 1'b1;
        pulses_left <= pulses_left - 3'h1;
      end else begin
        pulse_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_acc && paddr == ledp_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable <= pwdata[ledp_pkg::IRQ_W-1:0];
      end
      if (wr_acc && paddr == ledp_pkg::ADDR_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~pwdata[ledp_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_status <= irq_status | irq_ev;
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_off_when_disabled;
    @(posedge pclk) disable iff (!presetn)
      !ctrl.energy_watch_enable |=> state == ledp_pkg::LEDP_OFF;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) else $error("not off");

  property p_auto_wake;
    @(posedge pclk) disable iff (!presetn)
      state == ledp_pkg::LEDP_DOWN && ctrl.energy_watch_enable && ctrl.auto_wake_enable
      && data_met |=> state == ledp_pkg::LEDP_UP;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("no wake");

  property p_auto_sleep;
    @(posedge pclk) disable iff (!presetn)
      state == ledp_pkg::LEDP_UP && ctrl.energy_watch_enable && ctrl.auto_sleep_enable
      && !line_in.line_energy |=> state == ledp_pkg::LEDP_DOWN;
  endproperty
  a_auto_sleep: assert property (p_auto_sleep) else $error("no sleep");

  property p_manual_clears;
    @(posedge pclk) disable iff (!presetn)
      manual_req && state != ledp_pkg::LEDP_OFF && ctrl.energy_watch_enable
      |=> !manual_req || $past(wr_acc);
  endproperty
  a_manual_clears: assert property (p_manual_clears) else $error("manual stuck");

  property p_burst;
    @(posedge pclk) disable iff (!presetn)
      go_up && !ctrl.pulse_burst_disable |=> pulses_left == 3'h4 ##1 pulse_out ##1 !pulse_out
      ##1 pulse_out;
  endproperty
  a_burst: assert property (p_burst) else $error("burst wrong");

  property p_state_bit;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && paddr == ledp_pkg::ADDR_EDC |=>
      prdata[ledp_pkg::BIT_PWR_STATE] == $past(state == ledp_pkg::LEDP_UP) &&
      driver_power_on == $past(state == ledp_pkg::LEDP_UP);
  endproperty
  a_state_bit: assert property (p_state_bit) else $error("state bit");

  property p_err_hit;
    @(posedge pclk) disable iff (!presetn)
      ctrl.energy_watch_enable && err_met |=> error_threshold_hit;
  endproperty
  a_err_hit: assert property (p_err_hit) else $error("err flag");

  property p_data_hit_clear;
    @(posedge pclk) disable iff (!presetn)
      rd_edc && prdata[ledp_pkg::BIT_DATA_HIT] && !(ctrl.energy_watch_enable && data_met)
      |=> !data_threshold_hit;
  endproperty
  a_data_hit_clear: assert property (p_data_hit_clear) else $error("data flag");

  c_wake:   cover property (@(posedge pclk) disable iff (!presetn) go_up);
  c_sleep:  cover property (@(posedge pclk) disable iff (!presetn) go_down);
  c_manual: cover property (@(posedge pclk) disable iff (!presetn) manual_req && go_up);
endmodule
`default_nettype wire

// file: logic/ledp_pkg.sv
`default_nettype none
package ledp_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  REG_IDX_EDC      = 8'h1d;
  localparam logic [11:0] ADDR_EDC         = 12'h074;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h100;
  localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h104;
  localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h108;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_ENABLE     = 15;
  localparam int BIT_AUTO_WAKE  = 14;
  localparam int BIT_AUTO_SLEEP = 13;
  localparam int BIT_MANUAL     = 12;
  localparam int BIT_BURST_DIS  = 11;
  localparam int BIT_PWR_STATE  = 10;
  localparam int BIT_ERR_HIT    = 9;
  localparam int BIT_DATA_HIT   = 8;
  localparam int ERR_THR_LSB    = 4;
  localparam int DATA_THR_LSB   = 0;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [3:0] THR_RESET      = 4'h1;
  localparam logic [2:0] BURST_PULSES   = 3'h4;
  localparam logic [2:0] SINGLE_PULSE   = 3'h1;
  localparam longint     QUIET_TIME_MS  = 2000;
  localparam longint     CLK_HZ         = 100000000;
  localparam longint     QUIET_CYCLES   = QUIET_TIME_MS * CLK_HZ / 1000;
  localparam int         IRQ_W          = 4;

  typedef enum logic [1:0] {
    LEDP_OFF  = 2'b00,
    LEDP_DOWN = 2'b01,
    LEDP_UP   = 2'b10
  } ledp_state_t;

  typedef struct packed {
    logic       energy_watch_enable;
    logic       auto_wake_enable;
    logic       auto_sleep_enable;
    logic       pulse_burst_disable;
    logic [3:0] error_event_threshold;
    logic [3:0] data_event_threshold;
  } ledp_ctrl_t;

  typedef struct packed {
    logic line_energy;
    logic data_event;
    logic error_event;
  } ledp_line_t;
endpackage
`default_nettype wire
